// ---- design/axi_cmd_regs.sv ----
`timescale 1ns/1ps
// axi4-lite slave holding command, address, config, status, data
module axi_cmd_regs
  import flash_host_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // write channels
  input wire logic [flash_host_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [flash_host_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // to and from the sequencer
  output logic cmd_wr,
  output logic [2:0] cmd_code,
  output logic [23:0] erase_addr,
  output logic chip_alt,
  input wire logic [31:0] status_word,
  input wire logic [31:0] data_word
);
  import flash_host_pkg::*;

  logic aw_held, w_held; // channel captured
  logic [AXI_AW-1:0] wa; // captured write address
  logic [31:0] wd; // captured write data
  logic [3:0] ws; // captured strobes

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;

  // write path: address and data taken in either order
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wa <= '0;
      wd <= 32'h0000_0000;
      ws <= 4'h0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      cmd_wr <= 1'b0;
      cmd_code <= 3'h0;
      erase_addr <= 24'h00_0000;
      chip_alt <= 1'b0;
    end else if (ce) begin
      cmd_wr <= 1'b0;
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wa <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wd <= wdata;
        ws <= wstrb;
      end
      if (aw_held && w_held) begin
        // both present: perform and answer
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= RESP_OKAY;
        unique case (wa)
          OFS_CMD: begin
            if (ws[0]) begin
              cmd_code <= wd[2:0];
              cmd_wr <= 1'b1;
            end
          end
          OFS_ADDR: begin
            for (int i = 0; i < 3; i++) begin
              if (ws[i]) begin
                erase_addr[i*8 +: 8] <= wd[i*8 +: 8];
              end
            end
          end
          OFS_CFG: begin
            if (ws[0]) begin
              chip_alt <= wd[0];
            end
          end
          OFS_STATUS, OFS_DATA: ; // read only, write dropped
          default: bresp <= RESP_SLVERR;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // read path
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        unique case (araddr)
          OFS_CMD: rdata <= {29'h0, cmd_code};
          OFS_ADDR: rdata <= {8'h00, erase_addr};
          OFS_CFG: rdata <= {31'h0, chip_alt};
          OFS_STATUS: rdata <= status_word;
          OFS_DATA: rdata <= data_word;
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // axi_cmd_regs

// ---- design/flash_host.sv ----
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int SCK_HALF = 4,
  parameter int TIMER_W = 16
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // axi4-lite write address
  input wire logic [flash_host_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [flash_host_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // flash pins
  output logic flash_cs_n,
  output logic flash_sck,
  output logic flash_mosi,
  input wire logic flash_miso
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    st_idle,
    st_poll,
    st_pchk,
    st_wren,
    st_main,
    st_open,
    st_shift,
    st_gap,
    st_fin,
    st_wait
  } state_t;

  state_t state; // sequencer state
  state_t after_st; // where to go after the frame gap
  cmd_t cur; // command under way
  logic cmd_wr; // software command strobe
  logic [2:0] cmd_code; // raw command code
  logic [23:0] erase_addr; // block address
  logic chip_alt; // use alternate chip erase opcode
  logic [7:0] tx_buf [FRAME_MAX]; // outgoing frame bytes
  logic [2:0] n_bytes; // frame length
  logic [2:0] idx; // current byte
  logic byte_start; // start pulse to shifter
  logic byte_done; // shifter finished a byte
  logic [7:0] byte_rx; // byte shifted in
  logic [7:0] last_sr; // last device status byte
  logic [7:0] dev_id; // last device id
  logic [TIMER_W-1:0] gap_cnt; // chip select high time
  logic [TIMER_W-1:0] wait_cnt; // post command wait
  logic [TIMER_W-1:0] sus_guard; // spacing after resume
  logic suspended; // host copy of suspend flag
  logic powered_down; // host copy of power-down state
  logic erase_active; // erase believed running
  logic chip_active; // the running erase is a chip erase
  logic refused; // last command was refused
  logic refuse; // combinational refusal check
  logic [31:0] status_word; // status register image
  logic [31:0] data_word; // data register image

  // is a command an erase
  function automatic logic is_erase(input cmd_t c);
    return (c == CMD_BLOCK_ERASE) || (c == CMD_CHIP_ERASE);
  endfunction

  // is a command a release from power-down
  function automatic logic is_release(input cmd_t c);
    return (c == CMD_RELEASE) || (c == CMD_RELEASE_ID);
  endfunction

  // register block
  axi_cmd_regs u_regs (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .cmd_wr(cmd_wr),
    .cmd_code(cmd_code),
    .erase_addr(erase_addr),
    .chip_alt(chip_alt),
    .status_word(status_word),
    .data_word(data_word)
  );

  // byte shifter and serial clock divider
  spi_byte_io #(
    .HALF(SCK_HALF)
  ) u_shift (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .start(byte_start),
    .tx(tx_buf[idx]),
    .rx(byte_rx),
    .done(byte_done),
    .sck(flash_sck),
    .mosi(flash_mosi),
    .miso(flash_miso)
  );

  // register images
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_BUSY] = (state != st_idle);
    status_word[ST_REFUSED] = refused;
    status_word[ST_SUSPENDED] = suspended;
    status_word[ST_POWERED_DOWN] = powered_down;
    status_word[ST_ERASE_ACTIVE] = erase_active;
    data_word = {16'h0000, dev_id, last_sr};
  end

  // refusal check on a new software command
  always_comb begin
    refuse = 1'b0;
    if (powered_down && !is_release(cmd_t'(cmd_code))) begin
      refuse = 1'b1;
    end
    if (suspended && is_erase(cmd_t'(cmd_code))) begin
      refuse = 1'b1;
    end
    if (cmd_t'(cmd_code) == CMD_SUSPEND) begin
      // only a running block erase, once, and not too soon after resume
      if (suspended || !erase_active || chip_active) begin
        refuse = 1'b1;
      end
      if (sus_guard != '0) begin
        refuse = 1'b1;
      end
    end
    if (cmd_t'(cmd_code) == CMD_RESUME && !suspended) begin
      refuse = 1'b1;
    end
    if (is_release(cmd_t'(cmd_code)) && erase_active && !suspended) begin
      refuse = 1'b1;
    end
  end

  // spacing timer started by a resume
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sus_guard <= '0;
    end else if (ce) begin
      if (state == st_fin && cur == CMD_RESUME) begin
        sus_guard <= TIMER_W'(TSUS_CYC);
      end else if (sus_guard != '0) begin
        sus_guard <= sus_guard - 1'b1;
      end
    end
  end

  // command sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      after_st <= st_idle;
      cur <= CMD_READ_STATUS;
      for (int i = 0; i < FRAME_MAX; i++) begin
        tx_buf[i] <= 8'h00;
      end
      n_bytes <= LEN_ONE;
      idx <= 3'h0;
      byte_start <= 1'b0;
      flash_cs_n <= 1'b1;
      gap_cnt <= '0;
      wait_cnt <= '0;
      last_sr <= 8'h00;
      dev_id <= 8'h00;
      suspended <= 1'b0;
      powered_down <= 1'b0;
      erase_active <= 1'b0;
      chip_active <= 1'b0;
      refused <= 1'b0;
    end else if (ce) begin
      byte_start <= 1'b0;
      unique case (state)
        // wait for software
        st_idle: begin
          if (cmd_wr) begin
            cur <= cmd_t'(cmd_code);
            refused <= refuse;
            if (!refuse) begin
              // erase and resume first see the device idle
              if (is_erase(cmd_t'(cmd_code)) || cmd_t'(cmd_code) == CMD_RESUME) begin
                state <= st_poll;
              end else begin
                state <= st_main;
              end
            end
          end
        end
        // status read frame
        st_poll: begin
          tx_buf[0] <= OP_RDSR;
          tx_buf[1] <= DUMMY_BYTE;
          n_bytes <= LEN_STATUS;
          after_st <= st_pchk;
          state <= st_open;
        end
        // repeat until busy reads zero
        st_pchk: begin
          if (last_sr[SR_BUSY_BIT]) begin
            state <= st_poll;
          end else begin
            if (!suspended) begin
              erase_active <= 1'b0;
              chip_active <= 1'b0;
            end
            state <= (cur == CMD_RESUME) ? st_main : st_wren;
          end
        end
        // write enable before erase
        st_wren: begin
          tx_buf[0] <= OP_WREN;
          n_bytes <= LEN_ONE;
          after_st <= st_main;
          state <= st_open;
        end
        // build the command frame itself
        st_main: begin
          after_st <= st_fin;
          state <= st_open;
          unique case (cur)
            CMD_BLOCK_ERASE: begin
              tx_buf[0] <= OP_BLOCK_ERASE;
              tx_buf[1] <= erase_addr[23:16];
              tx_buf[2] <= erase_addr[15:8];
              tx_buf[3] <= erase_addr[7:0];
              n_bytes <= LEN_ADDR;
            end
            CMD_CHIP_ERASE: begin
              tx_buf[0] <= chip_alt ? OP_CHIP_ERASE_ALT : OP_CHIP_ERASE;
              n_bytes <= LEN_ONE;
            end
            CMD_SUSPEND: begin
              tx_buf[0] <= OP_SUSPEND;
              n_bytes <= LEN_ONE;
            end
            CMD_RESUME: begin
              tx_buf[0] <= OP_RESUME;
              n_bytes <= LEN_ONE;
            end
            CMD_POWER_DOWN: begin
              tx_buf[0] <= OP_POWER_DOWN;
              n_bytes <= LEN_ONE;
            end
            CMD_RELEASE: begin
              tx_buf[0] <= OP_RELEASE;
              n_bytes <= LEN_ONE;
            end
            CMD_RELEASE_ID: begin
              tx_buf[0] <= OP_RELEASE;
              tx_buf[1] <= DUMMY_BYTE;
              tx_buf[2] <= DUMMY_BYTE;
              tx_buf[3] <= DUMMY_BYTE;
              tx_buf[4] <= DUMMY_BYTE;
              n_bytes <= LEN_ID;
            end
            CMD_READ_STATUS: begin
              tx_buf[0] <= OP_RDSR;
              tx_buf[1] <= DUMMY_BYTE;
              n_bytes <= LEN_STATUS;
            end
          endcase
        end
        // select the device and start the first byte
        st_open: begin
          flash_cs_n <= 1'b0;
          idx <= 3'h0;
          byte_start <= 1'b1;
          state <= st_shift;
        end
        // run bytes; deselect right after the last bit
        st_shift: begin
          if (byte_done) begin
            if (idx == n_bytes - 3'h1) begin
              flash_cs_n <= 1'b1;
              if (n_bytes == LEN_STATUS) begin
                last_sr <= byte_rx;
              end
              if (n_bytes == LEN_ID) begin
                dev_id <= byte_rx;
              end
              gap_cnt <= TIMER_W'(GAP_CYC);
              state <= st_gap;
            end else begin
              idx <= idx + 3'h1;
              byte_start <= 1'b1;
            end
          end
        end
        // minimum deselect time between frames
        st_gap: begin
          if (gap_cnt == '0) begin
            state <= after_st;
          end else begin
            gap_cnt <= gap_cnt - 1'b1;
          end
        end
        // update host flags and choose the settling wait
        st_fin: begin
          state <= st_wait;
          wait_cnt <= '0;
          unique case (cur)
            CMD_BLOCK_ERASE: erase_active <= 1'b1;
            CMD_CHIP_ERASE: begin
              erase_active <= 1'b1;
              chip_active <= 1'b1;
            end
            CMD_SUSPEND: suspended <= 1'b1;
            CMD_RESUME: begin
              suspended <= 1'b0;
              wait_cnt <= TIMER_W'(RESUME_CYC);
            end
            CMD_POWER_DOWN: begin
              powered_down <= 1'b1;
              wait_cnt <= TIMER_W'(TDP_CYC);
            end
            CMD_RELEASE: begin
              powered_down <= 1'b0;
              wait_cnt <= TIMER_W'(WAKE_TIME_CYC);
            end
            CMD_RELEASE_ID: begin
              powered_down <= 1'b0;
              wait_cnt <= TIMER_W'(WAKE_WITH_ID_TIME_CYC);
            end
            CMD_READ_STATUS: begin
              if (!last_sr[SR_BUSY_BIT] && !suspended) begin
                erase_active <= 1'b0;
                chip_active <= 1'b0;
              end
            end
          endcase
        end
        // chip select stays high through the wait
        st_wait: begin
          if (wait_cnt == '0) begin
            state <= st_idle;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
      endcase
    end
  end
endmodule // flash_host

// ---- design/flash_host_pkg.sv ----
package flash_host_pkg;
  // controller clock period
  localparam int CLK_NS = 25;

  // nanoseconds to cycles, rounded up, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // device timing figures in ns (plain defaults where none is printed)
  localparam int TSUS_NS = 20000;
  localparam int TDP_NS = 3000;
  localparam int WAKE_TIME_NS = 3000;
  localparam int WAKE_WITH_ID_TIME_NS = 1800;
  localparam int RESUME_BUSY_NS = 200;
  localparam int GAP_NS = 100;
  localparam int TSUS_CYC = cyc_up(TSUS_NS);
  localparam int TDP_CYC = cyc_up(TDP_NS);
  localparam int WAKE_TIME_CYC = cyc_up(WAKE_TIME_NS);
  localparam int WAKE_WITH_ID_TIME_CYC = cyc_up(WAKE_WITH_ID_TIME_NS);
  localparam int RESUME_CYC = cyc_up(RESUME_BUSY_NS);
  localparam int GAP_CYC = cyc_up(GAP_NS);

  // serial opcodes
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_ALT = 8'h60;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // device status byte: busy bit
  localparam int SR_BUSY_BIT = 0;

  // frame sizes in bytes
  localparam int FRAME_MAX = 5;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_STATUS = 3'h2;
  localparam logic [2:0] LEN_ADDR = 3'h4;
  localparam logic [2:0] LEN_ID = 3'h5;

  // software commands
  typedef enum logic [2:0] {
    CMD_BLOCK_ERASE = 3'h0,
    CMD_CHIP_ERASE = 3'h1,
    CMD_SUSPEND = 3'h2,
    CMD_RESUME = 3'h3,
    CMD_POWER_DOWN = 3'h4,
    CMD_RELEASE = 3'h5,
    CMD_RELEASE_ID = 3'h6,
    CMD_READ_STATUS = 3'h7
  } cmd_t;

  // register byte offsets
  localparam int AXI_AW = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DATA = 8'h10;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_SUSPENDED = 2;
  localparam int ST_POWERED_DOWN = 3;
  localparam int ST_ERASE_ACTIVE = 4;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- design/spi_byte_io.sv ----
`timescale 1ns/1ps
// one byte, mode 0, msb first; serial clock made by dividing the core clock
module spi_byte_io #(
  parameter int HALF = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // byte request and answer
  input wire logic start,
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  output logic done,
  // serial pins
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  logic s1, s2, s3; // miso synchroniser stages
  logic miso_f; // filtered miso
  logic active; // byte in flight
  logic [7:0] shreg; // outgoing bits
  logic [2:0] bitn; // bit index
  logic [$clog2(HALF+1)-1:0] hcnt; // half period counter

  // three stage synchroniser, change taken when stages two and three agree
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      miso_f <= 1'b0;
    end else if (ce) begin
      s1 <= miso;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        miso_f <= s3;
      end
    end
  end

  // shift engine: rise latches mosi at the device, fall samples miso
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      active <= 1'b0;
      shreg <= 8'h00;
      rx <= 8'h00;
      bitn <= 3'h0;
      hcnt <= '0;
      sck <= 1'b0;
      mosi <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!active) begin
        if (start) begin
          active <= 1'b1;
          shreg <= {tx[6:0], 1'b0};
          mosi <= tx[7];
          bitn <= 3'h0;
          hcnt <= '0;
        end
      end else if (hcnt == ($clog2(HALF+1))'(HALF - 1)) begin
        hcnt <= '0;
        if (!sck) begin
          // rising edge
          sck <= 1'b1;
        end else begin
          // falling edge: sample late in the high phase
          sck <= 1'b0;
          rx <= {rx[6:0], miso_f};
          if (bitn == 3'h7) begin
            active <= 1'b0;
            done <= 1'b1;
          end else begin
            bitn <= bitn + 3'h1;
            mosi <= shreg[7];
            shreg <= {shreg[6:0], 1'b0};
          end
        end
      end else begin
        hcnt <= hcnt + 1'b1;
      end
    end
  end
endmodule // spi_byte_io

// ---- tb/flash_dev_model.sv ----
`timescale 1ns/1ps
// behavioural serial flash: status, erase, suspend, power-down
module flash_dev_model #(
  parameter int ERASE_NS = 20000,
  parameter logic [7:0] DEV_ID = 8'h3c // arbitrary value
) (
  // serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso
);
  logic [7:0] op, sh, tx;
  logic [23:0] addr;
  logic busy = 0, write_enable_latch = 0, halted_op_flag = 0, chip = 0, q = 0;
  logic pd = 0; // starts awake
  // no protection range or block lock is set, so no erase is skipped
  // no power loss here, so the halted flag clears only by resume
  int nb, left, erases = 0;
  // released line shows the inverse of the last bit
  assign miso = cs_n ? ~q : q;
  // frame start
  always @(negedge cs_n) nb = 0;
  // take bits on rising sck
  always @(posedge sck) begin
    sh = {sh[6:0], mosi};
    nb++;
    if (nb == 8) op = sh;
    if (nb > 8 && nb <= 32 && nb % 8 == 0) addr = {addr[15:0], sh};
  end
  // answer on falling sck, msb first
  always @(negedge sck) begin
    if (nb % 8 == 0) tx = (op == 8'h05 && !pd) ? {halted_op_flag, 5'h0, write_enable_latch, busy} :
      (op == 8'hab && nb >= 32 && !busy) ? DEV_ID : 8'h00;
    q = tx[7];
    tx = tx << 1;
  end
  // act on whole frames only
  always @(posedge cs_n) if (nb > 0 && nb % 8 == 0) begin
    if (op == 8'hab && !busy) pd = 0;
    else if (!pd) case (op)
      8'h06: write_enable_latch = 1;
      8'hd8, 8'hc7, 8'h60: if (write_enable_latch && !busy && !halted_op_flag && nb == (op == 8'hd8 ? 32 : 8)) begin
        busy = 1;
        chip = op != 8'hd8;
        left = ERASE_NS;
        erases++;
      end
      8'h75: if (!halted_op_flag && busy && !chip) {halted_op_flag, busy} = 2'b10;
      8'h7a: if (halted_op_flag && !busy) {halted_op_flag, busy} = 2'b01;
      8'hb9: if (!busy) pd = 1;
      default: ;
    endcase
  end
  // self-timed erase, paused while halted
  always #100 if (busy && left > 0) left -= 100;
    else if (busy) {busy, write_enable_latch} = 2'b00;
endmodule // flash_dev_model

// ---- tb/flash_host_asserts.sv ----
`timescale 1ns/1ps
// serial framing and response holds at the controller's ports
module flash_host_chk (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // bus responses
  input wire logic bvalid,
  input wire logic bready,
  input wire logic rvalid,
  input wire logic rready,
  // flash pins
  input wire logic flash_cs_n,
  input wire logic flash_sck,
  input wire logic flash_mosi
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sck_idle_a: assert property (flash_cs_n |-> !flash_sck)
    else $error("sck high while deselected");
  cs_gap_a: assert property ($rose(flash_cs_n) |=> flash_cs_n [*4])
    else $error("select gap short");
  sck_high_a: assert property ($rose(flash_sck) |-> flash_sck [*4] ##1 !flash_sck)
    else $error("sck high phase wrong");
  sck_low_a: assert property ($fell(flash_sck) |-> !flash_sck [*4])
    else $error("sck low phase short");
  mosi_hold_a: assert property (flash_sck |-> $stable(flash_mosi))
    else $error("mosi moved in sck high");
  cs_edge_a: assert property ($changed(flash_cs_n) |-> !flash_sck && !$past(flash_sck))
    else $error("select moved near sck");
  b_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("bvalid dropped");
  r_hold_a: assert property (rvalid && !rready |=> rvalid)
    else $error("rvalid dropped");
endmodule // flash_host_chk

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import flash_host_pkg::*;
  logic clock = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, r, b;
  logic ce = 1; // clock enable
  logic awready, wready, bvalid, arready, rvalid, cs_n, sck, mosi, miso;
  int num_errors = 0, compares = 0;
  flash_host dut (.clock, .nrst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .flash_cs_n(cs_n), .flash_sck(sck), .flash_mosi(mosi), .flash_miso(miso));
  flash_dev_model dev (.cs_n, .sck, .mosi, .miso);
  initial forever #12.5 clock = ~clock;
  task automatic chk(input string n, input logic [33:0] g, e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // bus write, then read
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do @(negedge clock); while (!(awready && wready));
    @(posedge clock);
    {awvalid, wvalid} <= 2'b00;
    do @(negedge clock); while (!bvalid);
    b = bresp;
    @(posedge clock);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(negedge clock); while (!arready);
    @(posedge clock);
    arvalid <= 0;
    do @(negedge clock); while (!rvalid);
    {r, d} = {rresp, rdata};
    @(posedge clock);
    rready <= 0;
  endtask
  // command, then wait for the sequencer to go idle
  task automatic cmd(input logic [2:0] c);
    wr(OFS_CMD, {29'h0, c});
    repeat (3) @(posedge clock);
    do rd(OFS_STATUS); while (d[ST_BUSY] !== 1'b0);
  endtask
  task automatic refused(input string n);
    rd(OFS_STATUS);
    chk(n, d[ST_REFUSED], 1);
  endtask
  // poll device status until the erase ends
  task automatic drain;
    do begin
      cmd(CMD_READ_STATUS);
      rd(OFS_DATA);
    end while (d[SR_BUSY_BIT] !== 1'b0);
  endtask
  task automatic t_erase;
    wr(OFS_ADDR, 32'h00a5c3e1);
    chk("addr write", b, RESP_OKAY);
    cmd(CMD_BLOCK_ERASE);
    chk("erases", dev.erases, 1);
    chk("addr", dev.addr, 24'ha5c3e1);
    cmd(CMD_RELEASE);
    refused("busy release");
    drain;
    chk("wel", dev.write_enable_latch, 0);
    rd(OFS_STATUS);
    chk("active", d[ST_ERASE_ACTIVE], 0);
  endtask
  task automatic t_susp;
    cmd(CMD_BLOCK_ERASE);
    cmd(CMD_SUSPEND);
    chk("halted", dev.halted_op_flag, 1);
    cmd(CMD_SUSPEND);
    refused("resuspend");
    cmd(CMD_BLOCK_ERASE);
    refused("halted erase");
    cmd(CMD_RESUME);
    chk("resumed", {dev.halted_op_flag, dev.busy}, 2'b01);
    cmd(CMD_SUSPEND);
    refused("early suspend");
    drain;
  endtask
  task automatic t_chip;
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CFG, i);
      cmd(CMD_CHIP_ERASE);
      chk("chip op", dev.op, i ? 8'h60 : 8'hc7);
      cmd(CMD_SUSPEND);
      chk("chip run", {dev.halted_op_flag, dev.busy}, 2'b01);
      drain;
    end
  endtask
  task automatic t_pd;
    cmd(CMD_POWER_DOWN);
    chk("pd", dev.pd, 1);
    cmd(CMD_READ_STATUS);
    refused("pd status");
    cmd(CMD_RELEASE_ID);
    rd(OFS_DATA);
    chk("id", d[15:8], dev.DEV_ID);
    cmd(CMD_POWER_DOWN);
    cmd(CMD_RELEASE);
    rd(OFS_STATUS);
    chk("awake", {d[ST_POWERED_DOWN], dev.pd}, 0);
    rd(8'h20);
    chk("unmapped", {r, d}, {RESP_SLVERR, 32'h0});
    wr(8'h20, 32'h0);
    chk("unmapped write", b, RESP_SLVERR);
  endtask
  // clock enable low freezes the link in mid-frame
  task automatic t_ce;
    logic [2:0] s;
    wr(OFS_CMD, {29'h0, CMD_READ_STATUS});
    // freeze lands in a low phase of the serial clock, first byte
    repeat (44) @(posedge clock);
    ce <= 0;
    @(negedge clock);
    s = {cs_n, sck, mosi};
    repeat (20) @(negedge clock);
    chk("frozen", {cs_n, sck, mosi}, s);
    @(posedge clock);
    ce <= 1;
    do rd(OFS_STATUS); while (d[ST_BUSY] !== 1'b0);
    rd(OFS_DATA);
    chk("sr after hold", d[7:0], {dev.halted_op_flag, 5'h0, dev.write_enable_latch, dev.busy});
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1;
    t_erase;
    t_susp;
    t_chip;
    t_ce;
    t_pd;
    print_verdict;
  end
  // hang guard
  initial begin
    #2500000;
    num_errors++;
    print_verdict;
  end
endmodule // testbench
bind flash_host flash_host_chk chk (.clock, .nrst, .bvalid, .bready, .rvalid, .rready,
  .flash_cs_n, .flash_sck, .flash_mosi);
